// File: logic/sdpsp_ctl.sv
// Purpose: bus controller driving one synchronous sram port
// Assumes: same clk_sys as the memory; one request at a time
// Notes: address bit 17 is the bank select for depth expansion
`timescale 1ns/1ns
`default_nettype none
module sdpsp_ctl (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire sdpsp_pkg::sdpsp_op_e req_op,
    input wire logic req_write,
    input wire logic [sdpsp_pkg::BANK_BIT:0] req_addr,
    input wire logic [sdpsp_pkg::DATA_W-1:0] req_wdata,
    input wire logic pipelined_mode,
    output logic resp_valid,
    output logic [sdpsp_pkg::DATA_W-1:0] resp_rdata,
    sdpsp_if.ctl bus
);
    typedef enum logic [2:0] {
        C_IDLE,
        C_ISSUE,
        C_DRAIN,
        C_WAIT,
        C_REWRITE
    } sdpsp_cst_e;

    sdpsp_cst_e state_q;
    logic last_read_q;
    logic rewrite_q;
    logic accept;

    assign req_ready = (state_q == C_IDLE);
    assign accept = req_valid & req_ready;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= C_IDLE;
        end else begin
            case (state_q)
                C_IDLE: if (accept) state_q <= C_ISSUE;
                C_ISSUE: begin
                    if (!bus.write_n) begin
                        state_q <= rewrite_q ? C_REWRITE : C_IDLE;
                    end else begin
                        state_q <= bus.latency_mode_select ? C_DRAIN
                                                           : C_WAIT;
                    end
                end
                C_DRAIN: state_q <= C_WAIT;
                C_WAIT: state_q <= C_IDLE;
                C_REWRITE: state_q <= C_IDLE;
                default: state_q <= C_IDLE;
            endcase
        end
    end

    // read-then-write history for the rewrite
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            last_read_q <= 1'b0;
            rewrite_q <= 1'b0;
        end else begin
            if (accept) begin
                rewrite_q <= req_write & last_read_q;
            end
            if (state_q == C_ISSUE) begin
                last_read_q <= bus.write_n;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // all pins change on the edge; the high select comes from the bank bit
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus.addr <= sdpsp_pkg::ADDR_RST;
            bus.ctl_dq_o <= sdpsp_pkg::DATA_RST;
            bus.ctl_dq_oe <= 1'b0;
            bus.write_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.chip_select_low_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.chip_select_high <= 1'b0;
            bus.address_load_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.count_advance_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.count_clear_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.output_enable_n <= sdpsp_pkg::PIN_INACTIVE;
            bus.latency_mode_select <= 1'b0;
        end else begin
            case (state_q)
                C_IDLE: if (accept) begin
                    bus.addr <= req_addr[sdpsp_pkg::ADDR_W-1:0];
                    bus.ctl_dq_o <= req_wdata;
                    bus.ctl_dq_oe <= req_write;
                    bus.write_n <= ~req_write;
                    bus.chip_select_low_n <= 1'b0;
                    bus.chip_select_high <= req_addr[sdpsp_pkg::BANK_BIT];
                    bus.address_load_n <= ~(req_op == sdpsp_pkg::OP_LOAD);
                    bus.count_advance_n <=
                        ~(req_op == sdpsp_pkg::OP_ADVANCE);
                    bus.count_clear_n <= ~(req_op == sdpsp_pkg::OP_CLEAR);
                    bus.latency_mode_select <= pipelined_mode;
                end
                C_ISSUE: begin
                    // later cycles repeat the same address
                    bus.address_load_n <= sdpsp_pkg::PIN_INACTIVE;
                    bus.count_advance_n <= sdpsp_pkg::PIN_INACTIVE;
                    bus.count_clear_n <= sdpsp_pkg::PIN_INACTIVE;
                    if (bus.write_n) begin
                        bus.output_enable_n <= 1'b0;
                        if (!bus.latency_mode_select) begin
                            bus.chip_select_low_n <= 1'b1;
                        end
                    end else if (!rewrite_q) begin
                        bus.chip_select_low_n <= 1'b1;
                        bus.ctl_dq_oe <= 1'b0;
                        bus.write_n <= 1'b1;
                    end
                end
                C_DRAIN: bus.chip_select_low_n <= 1'b1;
                C_WAIT: bus.output_enable_n <= 1'b1;
                C_REWRITE: begin
                    bus.chip_select_low_n <= 1'b1;
                    bus.ctl_dq_oe <= 1'b0;
                    bus.write_n <= 1'b1;
                end
                default: bus.chip_select_low_n <= 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // read response
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_rdata <= sdpsp_pkg::DATA_RST;
        end else begin
            resp_valid <= (state_q == C_WAIT);
            if (state_q == C_WAIT) begin
                resp_rdata <= bus.dq_bus;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/sdpsp_if.sv
// Purpose: pins between the sram port and its bus controller
// Assumes: both ends on clk_sys
// Notes: data bus level resolved here from the memory output enable
`timescale 1ns/1ns
`default_nettype none
interface sdpsp_if;
    logic [sdpsp_pkg::ADDR_W-1:0] addr;
    logic [sdpsp_pkg::DATA_W-1:0] ctl_dq_o;
    logic ctl_dq_oe;
    logic [sdpsp_pkg::DATA_W-1:0] mem_dq_o;
    logic mem_dq_oe;
    logic [sdpsp_pkg::DATA_W-1:0] dq_bus;
    logic write_n;
    logic chip_select_low_n;
    logic chip_select_high;
    logic address_load_n;
    logic count_advance_n;
    logic count_clear_n;
    logic output_enable_n;
    logic latency_mode_select;

    // memory wins when it drives, else the controller's value
    assign dq_bus = mem_dq_oe ? mem_dq_o : ctl_dq_o;

    modport ctl (
        output addr, ctl_dq_o, ctl_dq_oe, write_n, chip_select_low_n,
        output chip_select_high, address_load_n, count_advance_n,
        output count_clear_n, output_enable_n, latency_mode_select,
        input dq_bus
    );

    modport mem (
        input addr, write_n, chip_select_low_n, chip_select_high,
        input address_load_n, count_advance_n, count_clear_n,
        input output_enable_n, latency_mode_select, dq_bus,
        output mem_dq_o, mem_dq_oe
    );
endinterface
`default_nettype wire

// File: logic/sdpsp_mem_port.sv
// Purpose: one port of a synchronous 128K x 8 static memory
// Assumes: port clock is clk_sys; controls come from same-clock logic
// Notes: array is flip-flops without reset; no reset pin on the real part
`timescale 1ns/1ns
`default_nettype none
module sdpsp_mem_port (
    input wire logic clk_sys,
    input wire logic rst,
    sdpsp_if.mem bus,
    output logic powered_down,
    output logic [sdpsp_pkg::ADDR_W-1:0] access_addr,
    output logic write_strobe
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    logic [sdpsp_pkg::DATA_W-1:0] mem_q [0:sdpsp_pkg::DEPTH-1];
    logic [sdpsp_pkg::ADDR_W-1:0] addr_q;
    logic [sdpsp_pkg::ADDR_W-1:0] addr_d;
    logic [sdpsp_pkg::DATA_W-1:0] ft_data_q;
    logic [sdpsp_pkg::DATA_W-1:0] pipe_data_q;
    logic rd_q;
    logic pipe_oe_q;
    logic sel_now;
    logic rd_now;
    logic wr_now;
    logic drive;

    // ------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------
    // selection and access kind seen at the coming edge
    assign sel_now = sdpsp_pkg::sdpsp_selected(bus.chip_select_low_n,
                                               bus.chip_select_high);
    assign rd_now = sel_now & bus.write_n;
    assign wr_now = sel_now & ~bus.write_n;

    // ------------------------------------------------------------
    // address counter
    // ------------------------------------------------------------
    // next access address; clear outranks load, load outranks advance
    always_comb begin
        if (!bus.count_clear_n) begin
            addr_d = sdpsp_pkg::ADDR_RST;
        end else if (!bus.address_load_n) begin
            addr_d = bus.addr;
        end else if (!bus.count_advance_n) begin
            addr_d = addr_q + sdpsp_pkg::ADDR_ONE;
        end else begin
            addr_d = addr_q;
        end
    end

    // counter register, updated only on the rising edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_q <= sdpsp_pkg::ADDR_RST;
        end else begin
            addr_q <= addr_d;
        end
    end

    // ------------------------------------------------------------
    // array write
    // ------------------------------------------------------------
    // write lands in the same edge that takes the data; the access
    // uses the new address, so clear, load and advance all write
    // with no extra cycle
    always_ff @(posedge clk_sys) begin
        if (wr_now) begin
            mem_q[addr_d] <= bus.dq_bus;
        end
    end

    // pulse marking the cycle after an internal write
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_strobe <= 1'b0;
        end else begin
            write_strobe <= wr_now;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // first data stage, loaded only by a read so held data stays put
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ft_data_q <= sdpsp_pkg::DATA_RST;
        end else if (rd_now) begin
            ft_data_q <= mem_q[addr_d];
        end
    end

    // second data stage for the pipelined mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pipe_data_q <= sdpsp_pkg::DATA_RST;
        end else begin
            pipe_data_q <= ft_data_q;
        end
    end

    // ------------------------------------------------------------
    // output enable timing
    // ------------------------------------------------------------
    // read registered at this edge drives in the following cycle in flow-through mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= rd_now;
        end
    end

    // pipelined drive needs the read and one more selected edge
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pipe_oe_q <= 1'b0;
        end else begin
            pipe_oe_q <= rd_q & sel_now;
        end
    end

    // mode pin picks which stage faces the bus
    assign drive = bus.latency_mode_select ? pipe_oe_q : rd_q;
    assign bus.mem_dq_o = bus.latency_mode_select ? pipe_data_q
                                                  : ft_data_q;

    // output enable acts without the clock
    assign bus.mem_dq_oe = drive & ~bus.output_enable_n;

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    // one deselected edge puts the port in low power
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            powered_down <= 1'b1;
        end else begin
            powered_down <= ~sel_now;
        end
    end

    // current internal address for observation
    assign access_addr = addr_q;
endmodule
`default_nettype wire

// File: logic/sdpsp_pkg.sv
// Purpose: shared constants and types for the sram port and its controller
// Assumes: both ends run on clk_sys, asynchronous active high reset
// Notes: one side of the dual-port array is modelled; the other is not
// Operation
// - 128K by 8 array, 17-bit address
// - inputs captured only on rising clock edge
// - write strobe internal, needs no next edge
// - output enable gates data drivers combinationally
// - address load low loads external address
// - access address is external or counter value
// - count advance increments address, write uses it
// - no load, no advance: address and data hold
// - count advance high stalls the counter
// - counter clear costs no dead cycle
// - output state set by previous cycle controls
// - controller rewrites location when a write follows a read
// - one deselected cycle powers the port down
// - pipelined: two selected cycles before driving again
// - chip selects serve as bank selects
// - parallel devices share address and controls
// - latency mode high pipelined, low flow-through
// - deselect floats outputs after next edge
package sdpsp_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;
    localparam int DEPTH = 131072;
    localparam int BANK_BIT = 17;
    localparam logic [16:0] ADDR_RST = 17'h0_0000;
    localparam logic [16:0] ADDR_ONE = 17'h0_0001;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic PIN_INACTIVE = 1'b1;

    // access kind requested by the user of the controller
    typedef enum logic [1:0] {
        OP_LOAD,
        OP_ADVANCE,
        OP_HOLD,
        OP_CLEAR
    } sdpsp_op_e;

    // port is selected only with both chip selects active
    function automatic logic sdpsp_selected(input logic cs_low_n,
                                            input logic cs_high);
        sdpsp_selected = ~cs_low_n & cs_high;
    endfunction
endpackage

// File: verif/sdpsp_chk_sva.sv
// Purpose: pin checks on the link between controller and sram port
// Assumes: one clock, rst asynchronous active high
// Notes: sees the interface signals only
`timescale 1ns/1ns
`default_nettype none
module sdpsp_chk_sva (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic write_n,
    input wire logic chip_select_low_n,
    input wire logic chip_select_high,
    input wire logic address_load_n,
    input wire logic count_advance_n,
    input wire logic count_clear_n,
    input wire logic output_enable_n,
    input wire logic latency_mode_select,
    input wire logic ctl_dq_oe,
    input wire logic mem_dq_oe,
    input wire logic [sdpsp_pkg::DATA_W-1:0] ctl_dq_o
);
    logic sel;
    logic last_rd_q;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // port selected with both chip selects active
    assign sel = ~chip_select_low_n & chip_select_high;
    // kind of the last selected access
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst)
            last_rd_q <= 1'b0;
        else if (sel)
            last_rd_q <= write_n;
    end
    chk_oe_gates_drive: assert property (
        mem_dq_oe |-> !output_enable_n) else $error("drive while disabled");
    chk_deselect_floats: assert property (
        !sel |=> !mem_dq_oe) else $error("drive after deselect");
    chk_flow_drive: assert property (
        !latency_mode_select && $past(!latency_mode_select) |->
        mem_dq_oe == ($past(sel && write_n) && !output_enable_n))
        else $error("flow drive wrong");
    chk_pipe_drive: assert property (
        latency_mode_select && $past(latency_mode_select) &&
        $past(latency_mode_select, 2) |-> mem_dq_oe ==
        ($past(sel && write_n, 2) && $past(sel) && !output_enable_n))
        else $error("pipelined drive wrong");
    chk_pipe_two_sel: assert property (
        latency_mode_select && mem_dq_oe |-> $past(sel) && $past(sel, 2))
        else $error("pipelined drive too soon");
    chk_write_drives: assert property (
        sel && !write_n |-> ctl_dq_oe) else $error("write data not driven");
    chk_rewrite_after: assert property (
        sel && !write_n && last_rd_q |=> sel && !write_n && address_load_n
        && count_advance_n && count_clear_n && $stable(ctl_dq_o))
        else $error("no rewrite after read");
    chk_oe_after_read: assert property (
        !output_enable_n |-> $past(sel && write_n))
        else $error("enable without read");
    cov_flow_read: cover property (!latency_mode_select && mem_dq_oe);
    cov_pipe_read: cover property (latency_mode_select && mem_dq_oe);
    cov_rewrite: cover property (sel && !write_n && last_rd_q);
endmodule
`default_nettype wire

// File: verif/sync_dual_port_sram_port_test.sv
// Purpose: self-checking run of controller and sram port
// Assumes: both ends on clk_sys at 10 MHz
// Notes: model tracks the counter and written bytes
`timescale 1ns/1ns
`default_nettype none
module sync_dual_port_sram_port_test;
    logic clk_sys;
    logic rst;
    logic req_valid;
    logic req_ready;
    sdpsp_pkg::sdpsp_op_e req_op;
    logic req_write;
    logic [17:0] req_addr;
    logic [7:0] req_wdata;
    logic pipelined_mode;
    logic resp_valid;
    logic [7:0] resp_rdata;
    logic powered_down;
    logic [16:0] access_addr;
    logic write_strobe;
    logic [16:0] cnt;
    logic [7:0] mdl [int];
    logic prev_wr;
    logic [31:0] r;
    int err_total;
    int comparisons;
    int seed;
    int i;
    sdpsp_if sdpsp_if_i ();
    sdpsp_ctl sdpsp_ctl_i (.clk_sys(clk_sys), .rst(rst),
        .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .pipelined_mode(pipelined_mode), .resp_valid(resp_valid),
        .resp_rdata(resp_rdata), .bus(sdpsp_if_i));
    sdpsp_mem_port sdpsp_mem_port_i (.clk_sys(clk_sys), .rst(rst),
        .bus(sdpsp_if_i), .powered_down(powered_down),
        .access_addr(access_addr), .write_strobe(write_strobe));
    sdpsp_chk_sva sdpsp_chk_sva_i (.clk_sys(clk_sys), .rst(rst),
        .write_n(sdpsp_if_i.write_n),
        .chip_select_low_n(sdpsp_if_i.chip_select_low_n),
        .chip_select_high(sdpsp_if_i.chip_select_high),
        .address_load_n(sdpsp_if_i.address_load_n),
        .count_advance_n(sdpsp_if_i.count_advance_n),
        .count_clear_n(sdpsp_if_i.count_clear_n),
        .output_enable_n(sdpsp_if_i.output_enable_n),
        .latency_mode_select(sdpsp_if_i.latency_mode_select),
        .ctl_dq_oe(sdpsp_if_i.ctl_dq_oe), .mem_dq_oe(sdpsp_if_i.mem_dq_oe),
        .ctl_dq_o(sdpsp_if_i.ctl_dq_o));
    // clock source
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // verdict and end of run
    task automatic stop_test();
        $display("mismatches %0d of %0d checks", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one comparison
    task automatic chk(input string what, input logic [16:0] e,
                       input logic [16:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // one request: wait for take, update model, check answer
    task automatic do_req(input sdpsp_pkg::sdpsp_op_e op, input logic wr,
                          input logic [16:0] a, input logic [7:0] d);
        int n;
        int k;
        @(posedge clk_sys);
        req_valid <= 1'b1;
        req_op <= op;
        req_write <= wr;
        req_addr <= {1'b1, a};
        req_wdata <= d;
        n = 0;
        @(negedge clk_sys);
        while (req_ready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_total++;
                stop_test();
            end
            @(negedge clk_sys);
        end
        chk("access_addr", cnt, access_addr);
        @(posedge clk_sys);
        req_valid <= 1'b0;
        case (op)
            sdpsp_pkg::OP_LOAD: cnt = a;
            sdpsp_pkg::OP_ADVANCE: cnt = cnt + 17'h0_0001;
            sdpsp_pkg::OP_CLEAR: cnt = 17'h0_0000;
            default: ;
        endcase
        if (wr) begin
            mdl[cnt] = d;
            // strobe the cycle after the write, again after a rewrite
            for (k = 1; k <= 3; k++) begin
                @(negedge clk_sys);
                chk("write_strobe", 17'(k == 2 || (k == 3 && !prev_wr)),
                    17'(write_strobe));
            end
        end else begin
            k = 0;
            do begin
                @(negedge clk_sys);
                k++;
                if (k == 2)
                    chk("powered_down", 17'h0_0000, 17'(powered_down));
            end while (resp_valid !== 1'b1 && k < 8);
            chk("latency", 17'(pipelined_mode ? 4 : 3), 17'(k));
            if (mdl.exists(cnt))
                chk("rdata", 17'(mdl[cnt]), 17'(resp_rdata));
            chk("powered_down", 17'h0_0001, 17'(powered_down));
            if (resp_valid !== 1'b1)
                stop_test();
        end
        prev_wr = wr;
    endtask
    // reset, fill, boundary, random traffic in both modes
    initial begin
        seed = 97;
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = sdpsp_pkg::OP_HOLD;
        req_write = 1'b0;
        req_addr = 18'h0_0000;
        req_wdata = 8'h00;
        pipelined_mode = 1'b0;
        cnt = 17'h0_0000;
        prev_wr = 1'b1; // no read seen yet, so no rewrite due
        err_total = 0;
        comparisons = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            do_req(sdpsp_pkg::OP_LOAD, 1'b1, 17'(i), r[7:0]);
        end
        for (i = 0; i < 2; i++) begin
            @(posedge clk_sys);
            pipelined_mode <= i[0];
            do_req(sdpsp_pkg::OP_LOAD, 1'b1, 17'h1_ffff, 8'ha5);
            do_req(sdpsp_pkg::OP_ADVANCE, 1'b0, 17'h0_0000, 8'h00);
            do_req(sdpsp_pkg::OP_LOAD, 1'b0, 17'h1_ffff, 8'h00);
            repeat (60) begin
                r = $random(seed);
                do_req(sdpsp_pkg::sdpsp_op_e'(r[1:0]), r[4], 17'(r[11:8]),
                       r[23:16]);
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
